/* mcsc_pkg.sv */
/*
  Constants for the master clock source control block: register offsets,
  field positions, reset values and switch-over timing.
  Assumes a 250 MHz pclk and an APB master with 32-bit data.
*/
package mcsc_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] MCSC_OFS_CFG_ONE  = 8'h00;
  localparam logic [7:0] MCSC_OFS_CFG_TWO  = 8'h04;
  localparam logic [7:0] MCSC_OFS_IN_EN    = 8'h08;
  localparam logic [7:0] MCSC_OFS_LOOP     = 8'h0C;
  localparam logic [7:0] MCSC_OFS_GPIO     = 8'h10;
  localparam logic [7:0] MCSC_OFS_STATUS   = 8'h14;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int MCSC_F_BUF_MODE_LO = 0;
  localparam int MCSC_F_DOUBLER     = 2;
  localparam int MCSC_F_MCLK_SEL    = 3;
  localparam int MCSC_F_RING_DIS    = 4;
  localparam int MCSC_F_MUX_LO      = 0;
  localparam int MCSC_F_DLOOP_EN    = 3;
  localparam int MCSC_F_GPIO_OUT    = 0;
  localparam int MCSC_F_GPIO_OE     = 1;

  localparam logic [1:0] MCSC_BUF_SINGLE = 2'h2;
  localparam logic [1:0] MCSC_BUF_XTAL   = 2'h1;
  localparam logic [1:0] MCSC_MUX_DLOOP  = 2'h3;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [4:0] MCSC_RST_CFG_ONE = 5'h00;
  localparam logic [7:0] MCSC_RST_CFG_TWO = 8'h00;
  localparam logic [2:0] MCSC_RST_IN_EN   = 3'h0;
  localparam logic [3:0] MCSC_RST_LOOP    = 4'h0;
  localparam logic [1:0] MCSC_RST_GPIO    = 2'h0;

  // ****************************************************************
  // Switch-over timing
  // ****************************************************************
  localparam int MCSC_CLK_PERIOD_NS = 4;
  localparam int MCSC_DEAD_TIME_NS  = 20;
  localparam logic [3:0] MCSC_DEAD_CYCLES =
    4'((MCSC_DEAD_TIME_NS + MCSC_CLK_PERIOD_NS - 1) / MCSC_CLK_PERIOD_NS);

  typedef enum logic [3:0] {
    MCSC_SW_RING = 4'h1,
    MCSC_SW_R2E  = 4'h2,
    MCSC_SW_EXT  = 4'h4,
    MCSC_SW_E2R  = 4'h8
  } mcsc_sw_t;

endpackage : mcsc_pkg

/* mcsc_top.sv */
/*
  Master clock source control: APB register file, reference pin mode,
  doubler, ring oscillator power, input receiver enables, third input
  GPIO and the break-before-make master clock switch sequencer.
  Assumes a single 250 MHz pclk and an APB master; gate enables drive
  an analog clock mux outside this block.
*/
`timescale 1ns/1ns
module mcsc_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        third_input_pos_i,
  output logic             third_input_pos_o,
  output logic             third_input_pos_oe,
  output logic             ref_primary_single_en,
  output logic             xtal_driver_en,
  output logic             doubler_en,
  output logic             ring_osc_pd,
  output logic             ring_gate_en,
  output logic             ext_gate_en,
  output logic [2:0]       input_rx_en,
  output logic             input_block_run,
  output logic [7:0]       master_freq
);

  // ****************************************************************
  // Address decode
  // ****************************************************************
  function automatic logic mcsc_hit(input logic [7:0] a, input logic [7:0] ofs);
    mcsc_hit = (a == ofs);
  endfunction : mcsc_hit

  logic [4:0] master_cfg_one;
  logic [7:0] master_cfg_two;
  logic [2:0] input_enable_reg;
  logic [3:0] loop_cfg;
  logic [1:0] gpio_cfg;
  logic [4:0] next_master_cfg_one;
  logic [7:0] next_master_cfg_two;
  logic [2:0] next_input_enable_reg;
  logic [3:0] next_loop_cfg;
  logic [1:0] next_gpio_cfg;
  logic       wr_cmt;
  logic       mapped;
  logic       gpio_meta;
  logic       gpio_sync;
  logic       combined_mode;

  assign wr_cmt = psel & penable & pready & pwrite;
  assign mapped = mcsc_hit(paddr, mcsc_pkg::MCSC_OFS_CFG_ONE) |
                  mcsc_hit(paddr, mcsc_pkg::MCSC_OFS_CFG_TWO) |
                  mcsc_hit(paddr, mcsc_pkg::MCSC_OFS_IN_EN)   |
                  mcsc_hit(paddr, mcsc_pkg::MCSC_OFS_LOOP)    |
                  mcsc_hit(paddr, mcsc_pkg::MCSC_OFS_GPIO)    |
                  mcsc_hit(paddr, mcsc_pkg::MCSC_OFS_STATUS);

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  always_comb begin
    next_master_cfg_one   = master_cfg_one;
    next_master_cfg_two   = master_cfg_two;
    next_input_enable_reg = input_enable_reg;
    next_loop_cfg         = loop_cfg;
    next_gpio_cfg         = gpio_cfg;
    if (wr_cmt && mcsc_hit(paddr, mcsc_pkg::MCSC_OFS_CFG_ONE)) begin
      next_master_cfg_one = pwdata[4:0];
    end
    if (wr_cmt && mcsc_hit(paddr, mcsc_pkg::MCSC_OFS_CFG_TWO)) begin
      next_master_cfg_two = pwdata[7:0];
    end
    if (wr_cmt && mcsc_hit(paddr, mcsc_pkg::MCSC_OFS_IN_EN)) begin
      next_input_enable_reg = pwdata[2:0];
    end
    if (wr_cmt && mcsc_hit(paddr, mcsc_pkg::MCSC_OFS_LOOP)) begin
      next_loop_cfg = pwdata[3:0];
    end
    if (wr_cmt && mcsc_hit(paddr, mcsc_pkg::MCSC_OFS_GPIO)) begin
      next_gpio_cfg = pwdata[1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      master_cfg_one   <= mcsc_pkg::MCSC_RST_CFG_ONE;
      master_cfg_two   <= mcsc_pkg::MCSC_RST_CFG_TWO;
      input_enable_reg <= mcsc_pkg::MCSC_RST_IN_EN;
      loop_cfg         <= mcsc_pkg::MCSC_RST_LOOP;
      gpio_cfg         <= mcsc_pkg::MCSC_RST_GPIO;
    end else begin
      master_cfg_one   <= next_master_cfg_one;
      master_cfg_two   <= next_master_cfg_two;
      input_enable_reg <= next_input_enable_reg;
      loop_cfg         <= next_loop_cfg;
      gpio_cfg         <= next_gpio_cfg;
    end
  end

  // Combined loop: mux code 11x with digital loop on
  assign combined_mode = (loop_cfg[2:1] == mcsc_pkg::MCSC_MUX_DLOOP) &
                         loop_cfg[mcsc_pkg::MCSC_F_DLOOP_EN];

  // ****************************************************************
  // Master clock switch sequencer
  // ****************************************************************
  mcsc_pkg::mcsc_sw_t sw_state;
  mcsc_pkg::mcsc_sw_t next_sw_state;
  logic [3:0]         dead_cnt;
  logic [3:0]         next_dead_cnt;
  logic               want_ext;

  assign want_ext = master_cfg_one[mcsc_pkg::MCSC_F_MCLK_SEL];

  // Both gates stay off for the dead time so no runt pulse escapes
  always_comb begin
    next_sw_state = sw_state;
    next_dead_cnt = dead_cnt;
    unique case (sw_state)
      mcsc_pkg::MCSC_SW_RING: begin
        if (want_ext) begin
          next_sw_state = mcsc_pkg::MCSC_SW_R2E;
          next_dead_cnt = mcsc_pkg::MCSC_DEAD_CYCLES;
        end
      end
      mcsc_pkg::MCSC_SW_R2E: begin
        if (dead_cnt > 4'h1) begin
          next_dead_cnt = dead_cnt - 4'h1;
        end else begin
          next_dead_cnt = 4'h0;
          next_sw_state = want_ext ? mcsc_pkg::MCSC_SW_EXT : mcsc_pkg::MCSC_SW_RING;
        end
      end
      mcsc_pkg::MCSC_SW_EXT: begin
        if (!want_ext) begin
          next_sw_state = mcsc_pkg::MCSC_SW_E2R;
          next_dead_cnt = mcsc_pkg::MCSC_DEAD_CYCLES;
        end
      end
      mcsc_pkg::MCSC_SW_E2R: begin
        if (dead_cnt > 4'h1) begin
          next_dead_cnt = dead_cnt - 4'h1;
        end else begin
          next_dead_cnt = 4'h0;
          next_sw_state = want_ext ? mcsc_pkg::MCSC_SW_EXT : mcsc_pkg::MCSC_SW_RING;
        end
      end
      default: begin
        next_sw_state = mcsc_pkg::MCSC_SW_RING;
        next_dead_cnt = 4'h0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_state <= mcsc_pkg::MCSC_SW_RING;
      dead_cnt <= 4'h0;
    end else begin
      sw_state <= next_sw_state;
      dead_cnt <= next_dead_cnt;
    end
  end

  // ****************************************************************
  // Pin controls and APB answer
  // ****************************************************************
  logic        next_pready;
  logic [31:0] next_prdata;
  logic        next_pslverr;
  logic [31:0] status_word;

  assign status_word = {26'h0, combined_mode, ring_osc_pd, gpio_sync,
                        sw_state == mcsc_pkg::MCSC_SW_EXT,
                        sw_state == mcsc_pkg::MCSC_SW_RING,
                        sw_state == mcsc_pkg::MCSC_SW_R2E || sw_state == mcsc_pkg::MCSC_SW_E2R};

  always_comb begin
    next_pready  = psel & ~penable;
    next_pslverr = psel & ~penable & ~mapped;
    next_prdata  = 32'h0;
    if (psel && !penable && !pwrite) begin
      if (mcsc_hit(paddr, mcsc_pkg::MCSC_OFS_CFG_ONE)) next_prdata = {27'h0, master_cfg_one};
      if (mcsc_hit(paddr, mcsc_pkg::MCSC_OFS_CFG_TWO)) next_prdata = {24'h0, master_cfg_two};
      if (mcsc_hit(paddr, mcsc_pkg::MCSC_OFS_IN_EN))   next_prdata = {29'h0, input_enable_reg};
      if (mcsc_hit(paddr, mcsc_pkg::MCSC_OFS_LOOP))    next_prdata = {28'h0, loop_cfg};
      if (mcsc_hit(paddr, mcsc_pkg::MCSC_OFS_GPIO))    next_prdata = {30'h0, gpio_cfg};
      if (mcsc_hit(paddr, mcsc_pkg::MCSC_OFS_STATUS))  next_prdata = status_word;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready                <= 1'b0;
      prdata                <= 32'h0;
      pslverr               <= 1'b0;
      gpio_meta             <= 1'b0;
      gpio_sync             <= 1'b0;
      ref_primary_single_en <= 1'b0;
      xtal_driver_en        <= 1'b0;
      doubler_en            <= 1'b0;
      ring_osc_pd           <= 1'b0;
      ring_gate_en          <= 1'b1;
      ext_gate_en           <= 1'b0;
      input_rx_en           <= 3'h0;
      input_block_run       <= 1'b0;
      third_input_pos_o     <= 1'b0;
      third_input_pos_oe    <= 1'b0;
      master_freq           <= 8'h0;
    end else begin
      pready                <= next_pready;
      prdata                <= next_prdata;
      pslverr               <= next_pslverr;
      gpio_meta             <= third_input_pos_i;
      gpio_sync             <= gpio_meta;
      ref_primary_single_en <= master_cfg_one[1:0] == mcsc_pkg::MCSC_BUF_SINGLE;
      xtal_driver_en        <= master_cfg_one[1:0] == mcsc_pkg::MCSC_BUF_XTAL;
      doubler_en            <= master_cfg_one[mcsc_pkg::MCSC_F_DOUBLER];
      // Ring stays powered until the bus has moved to the external clock
      ring_osc_pd           <= master_cfg_one[mcsc_pkg::MCSC_F_RING_DIS] &
                               (next_sw_state == mcsc_pkg::MCSC_SW_EXT);
      ring_gate_en          <= next_sw_state == mcsc_pkg::MCSC_SW_RING;
      ext_gate_en           <= next_sw_state == mcsc_pkg::MCSC_SW_EXT;
      input_rx_en           <= input_enable_reg;
      input_block_run       <= (next_sw_state == mcsc_pkg::MCSC_SW_EXT) &
                               loop_cfg[mcsc_pkg::MCSC_F_DLOOP_EN];
      third_input_pos_o     <= gpio_cfg[mcsc_pkg::MCSC_F_GPIO_OUT];
      third_input_pos_oe    <= gpio_cfg[mcsc_pkg::MCSC_F_GPIO_OE] & ~input_enable_reg[2];
      master_freq           <= master_cfg_two;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_dead_gap;
    (!ring_gate_en && !ext_gate_en) [*5];
  endsequence

  a_gates_exclusive: assert property (!(ring_gate_en && ext_gate_en))
    else $error("both clock gates on");
  a_gap_before_ext: assert property ($rose(ext_gate_en) |-> $past(!ring_gate_en, 5))
    else $error("external gate opened without dead time");
  a_switch_dead_time: assert property ($fell(ring_gate_en) |-> s_dead_gap)
    else $error("dead time too short");
  a_single_mode: assert property (ref_primary_single_en |-> $past(master_cfg_one[1:0]) == 2'h2)
    else $error("single-ended input on without mode 10");
  a_xtal_mode: assert property (xtal_driver_en |->
    !ref_primary_single_en && $past(master_cfg_one[1:0]) == mcsc_pkg::MCSC_BUF_XTAL)
    else $error("crystal driver and single-ended input both on");
  a_doubler_follow: assert property ($rose(master_cfg_one[2]) |=> doubler_en)
    else $error("doubler did not follow its bit");
  a_ring_pd_safe: assert property (ring_osc_pd |-> ext_gate_en)
    else $error("ring powered down while in use");
  a_rx_enable: assert property (input_rx_en == $past(input_enable_reg))
    else $error("receiver enable mismatch");
  a_gpio_exclusive: assert property (third_input_pos_oe |-> !input_rx_en[2])
    else $error("third input driven while a clock input");
  a_block_master: assert property (input_block_run |-> ext_gate_en)
    else $error("input block running off the ring oscillator");
  a_ring_at_start: assert property ($rose(presetn) |-> ring_gate_en)
    else $error("bus not on ring oscillator after reset");

endmodule : mcsc_top

/* mcsc_pin_model.sv */
/*
  Far-side model of the third input positive pin: an outside driver
  that may hold a level on the pin while the block leaves it as input.
  Assumes the bench resolves nothing else on this wire.
*/
`timescale 1ns/1ns
module mcsc_pin_model (
  input  wire logic pclk,
  input  wire logic dut_o,
  input  wire logic dut_oe,
  input  wire logic drv_en,
  input  wire logic drv_lvl,
  output logic      pin
);
  logic toggle = 1'b0;
  always @(posedge pclk) begin
    toggle <= ~toggle;
  end
  // Undriven pin shows a moving pattern, never a stale level
  assign pin = dut_oe ? dut_o : (drv_en ? drv_lvl : toggle);
endmodule : mcsc_pin_model

/* tb.sv */
/*
  Self-checking bench for the master clock source control block.
  Assumes mcsc_pkg and mcsc_top are compiled first.
*/
`timescale 1ns/1ns
module tb;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, v;
  logic        pready, pslverr, pin, pin_o, pin_oe, single_en, xtal_en, dbl_en;
  logic        ring_pd, ring_gate_en, ext_gate_en, run;
  logic [31:0] prdata;
  logic [2:0]  rx_en;
  logic [7:0]  freq;
  logic        drv_en = 1, drv_lvl = 0;
  logic [32:0] expq[$];
  int          err_total = 0, compares = 0;

  always #2 pclk = ~pclk;

  mcsc_top mcsc_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .third_input_pos_i(pin), .third_input_pos_o(pin_o),
    .third_input_pos_oe(pin_oe), .ref_primary_single_en(single_en),
    .xtal_driver_en(xtal_en), .doubler_en(dbl_en), .ring_osc_pd(ring_pd),
    .ring_gate_en(ring_gate_en), .ext_gate_en(ext_gate_en), .input_rx_en(rx_en),
    .input_block_run(run), .master_freq(freq));

  mcsc_pin_model mcsc_pin_model_inst (.pclk(pclk), .dut_o(pin_o), .dut_oe(pin_oe),
    .drv_en(drv_en), .drv_lvl(drv_lvl), .pin(pin));

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task test_done;
    $display("Compares %0d errors %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : test_done

  task check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("Error t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask : check

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
    int n;
    n = 0;
    expq.push_back(e);
    @(posedge pclk);
    psel    <= 1;
    penable <= 0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_total++;
      test_done();
    end
    psel    <= 0;
    penable <= 0;
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, {1'b0, e});
  endtask : rd

  task settle;
    repeat (2) @(posedge pclk);
    #1;
  endtask : settle

  task sw_wait(input logic to_ext);
    int n, lows;
    n = 0;
    lows = 0;
    while (!(to_ext ? ext_gate_en === 1'b1 : ring_gate_en === 1'b1) && n < 50) begin
      @(posedge pclk);
      #1;
      n++;
      if (ring_gate_en === 1'b0 && ext_gate_en === 1'b0)
        lows++;
    end
    if (n >= 50) begin
      err_total++;
      test_done();
    end
    check(32'(lows), 32'h5);
  endtask : sw_wait

  // ****************************************************************
  // Response watcher
  // ****************************************************************
  always @(posedge pclk) begin : mon
    logic [32:0] e;
    if (pready === 1'b1) begin
      e = (expq.size() > 0) ? expq.pop_front() : 33'h1FFFFFFFF;
      check(prdata, e[31:0]);
      check({31'h0, pslverr}, {31'h0, e[32]});
    end
  end

  always @(negedge pclk) begin
    if (ring_gate_en === 1'b1 && ext_gate_en === 1'b1)
      check(32'h1, 32'h0);
  end

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    void'($urandom(32'hD5AC));
    repeat (3) @(posedge pclk);
    presetn <= 1;
    #1;
    check({31'h0, ring_gate_en}, 32'h1);
    check({31'h0, ext_gate_en}, 32'h0);
    rd(mcsc_pkg::MCSC_OFS_CFG_ONE, 32'h0);
    rd(mcsc_pkg::MCSC_OFS_STATUS, 32'h2);
    for (int m = 0; m < 8; m++) begin
      wr(mcsc_pkg::MCSC_OFS_CFG_ONE, 32'(m));
      settle();
      check({31'h0, single_en}, {31'h0, m[1:0] == 2'h2});
      check({31'h0, xtal_en}, {31'h0, m[1:0] == 2'h1});
      check({31'h0, dbl_en}, {31'h0, m[2]});
      rd(mcsc_pkg::MCSC_OFS_CFG_ONE, 32'(m));
    end
    repeat (4) begin
      v = $urandom;
      wr(mcsc_pkg::MCSC_OFS_IN_EN, v);
      settle();
      check({29'h0, rx_en}, {29'h0, v[2:0]});
      rd(mcsc_pkg::MCSC_OFS_IN_EN, {29'h0, v[2:0]});
    end
    wr(mcsc_pkg::MCSC_OFS_IN_EN, 32'h0);
    wr(mcsc_pkg::MCSC_OFS_GPIO, 32'h3);
    settle();
    check({30'h0, pin_oe, pin_o}, 32'h3);
    wr(mcsc_pkg::MCSC_OFS_IN_EN, 32'h4);
    settle();
    check({31'h0, pin_oe}, 32'h0);
    drv_lvl <= 1;
    wr(mcsc_pkg::MCSC_OFS_GPIO, 32'h0);
    settle();
    rd(mcsc_pkg::MCSC_OFS_STATUS, 32'hA);
    // Reference frequency and error trim stay software duties
    v = $urandom;
    wr(mcsc_pkg::MCSC_OFS_CFG_TWO, v);
    settle();
    check({24'h0, freq}, {24'h0, v[7:0]});
    apb(1'b1, 8'h18, 32'hFFFF, {1'b1, 32'h0});
    apb(1'b0, 8'h1C, 32'h0, {1'b1, 32'h0});
    wr(mcsc_pkg::MCSC_OFS_STATUS, 32'h3F);
    rd(mcsc_pkg::MCSC_OFS_STATUS, 32'hA);
    wr(mcsc_pkg::MCSC_OFS_LOOP, 32'hE);
    wr(mcsc_pkg::MCSC_OFS_CFG_ONE, 32'h10);
    settle();
    check({31'h0, ring_pd}, 32'h0);
    check({31'h0, run}, 32'h0);
    wr(mcsc_pkg::MCSC_OFS_CFG_ONE, 32'h18);
    sw_wait(1'b1);
    settle();
    check({31'h0, ring_pd}, 32'h1);
    check({31'h0, run}, 32'h1);
    rd(mcsc_pkg::MCSC_OFS_STATUS, 32'h3C);
    wr(mcsc_pkg::MCSC_OFS_CFG_ONE, 32'h10);
    sw_wait(1'b0);
    settle();
    check({30'h0, ring_pd, run}, 32'h0);
    rd(mcsc_pkg::MCSC_OFS_STATUS, 32'h2A);
    // Mid-run reset while on the external clock with the ring powered down
    wr(mcsc_pkg::MCSC_OFS_CFG_ONE, 32'h18);
    sw_wait(1'b1);
    check({31'h0, ring_pd}, 32'h1);
    @(posedge pclk);
    presetn <= 0;
    repeat (3) @(posedge pclk);
    presetn <= 1;
    #1;
    check({29'h0, ring_gate_en, ext_gate_en, ring_pd}, 32'h4);
    rd(mcsc_pkg::MCSC_OFS_CFG_ONE, 32'h0);
    rd(mcsc_pkg::MCSC_OFS_STATUS, 32'hA);
    repeat (4) @(posedge pclk);
    check(32'(expq.size()), 32'h0);
    test_done();
  end
endmodule : tb
